// >>> io_bus_regs_and_power_ctrl_tb_top.sv
`timescale 1ns/10ps
module io_bus_regs_and_power_ctrl_tb_top;
    localparam [75:0] rst_vals = 76'hf7ff0ff0ffffbf0ffff;
    localparam [79:0] rd_tab   = 80'ha1601034f2959c534926;
    localparam [15:0] css_div  = 16'h731f;
    localparam [19:0] osc_tab  = 20'h8a4a2;
    reg         mclk, rstn, irq, wlock, ok;
    reg  [3:0]  p2p, p4p, p5p, vms, wclr, sst, got;
    reg  [7:0]  srx;
    reg  [23:0] rows [0:25];
    wire        wr, rd, sx, rv, txl, ies, slp, ccr, pcr, rc1, rc2, x4m;
    wire        x32, ext, bor, d16, dsy;
    wire [3:0]  ad, wd, rdat, p2d, p2r, p4d, p5d, scf, cmg, sc1, ssc, sc2;
    wire [3:0]  rom, volt_mon_ctrl, t2c, timer2_mode_1, timer2_mode_2, timer2_cmp_mode, t2o1, timer1_ctrl_1, timer1_ctrl_2, watchdog_ctrl, cdm;
    wire [7:0]  p4c, p5c, stx, t2o2;
    wire [75:0] all4 = {watchdog_ctrl, timer1_ctrl_2, timer1_ctrl_1, t2o1, timer2_cmp_mode, timer2_mode_2, timer2_mode_1, t2c, sc2,
                        sc1, cmg, p2r, ssc, volt_mon_ctrl, rom, scf, p5d, p4d, p2d};
    integer     errors, n_compared, i;
    iob_regs uut (
        .mclk_i(mclk), .rstn_i(rstn), .io_wr_i(wr), .io_rd_i(rd),
        .io_addr_i(ad), .io_wdata_i(wd), .sleep_exec_i(sx), .irq_any_i(irq),
        .wdt_lock_i(wlock), .port2_pins_i(p2p), .port4_pins_i(p4p),
        .port5_pins_i(p5p), .ser_rx_i(srx), .vm_status_i(vms),
        .wdt_clear_i(wclr), .ser_status_i(sst), .io_rdata_o(rdat),
        .io_rvalid_o(rv), .port2_data_o(p2d), .port2_dir_o(p2r),
        .port4_data_o(p4d), .port4_ctrl_o(p4c), .port5_data_o(p5d),
        .port5_ctrl_o(p5c), .sys_config_o(scf), .clock_mgmt_o(cmg),
        .ser_tx_o(stx), .ser_tx_load_o(txl), .ser_ctrl1_o(sc1),
        .ser_statctl_o(ssc), .ser_ctrl2_o(sc2), .rom_bank_o(rom),
        .volt_mon_ctrl_o(volt_mon_ctrl), .t2_ctrl_o(t2c), .t2_mode1_o(timer2_mode_1),
        .t2_mode2_o(timer2_mode_2), .t2_cmpmode_o(timer2_cmp_mode), .t2_cmp1_o(t2o1),
        .t2_cmp2_o(t2o2), .t1_ctrl1_o(timer1_ctrl_1), .t1_ctrl2_o(timer1_ctrl_2),
        .wdt_ctrl_o(watchdog_ctrl), .irq_enable_set_o(ies), .sleep_o(slp),
        .core_clk_run_o(ccr), .periph_clk_run_o(pcr), .rc1_run_o(rc1),
        .rc2_run_o(rc2), .xt4m_run_o(x4m), .xt32k_run_o(x32),
        .ext_clk_run_o(ext), .brownout_run_o(bor),
        .periph_div16_o(d16), .core_div_m1_o(cdm), .div_sync_o(dsy)
    );
    iob_core_model core (
        .mclk_i(mclk), .io_rdata_i(rdat), .io_rvalid_i(rv), .io_wr_o(wr),
        .io_rd_o(rd), .io_addr_o(ad), .io_wdata_o(wd), .sleep_exec_o(sx)
    );
    always #2 mclk = ~mclk;
    task chk(input [23:0] g, input [23:0] e);
        n_compared = n_compared + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("BAD %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task stop_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task do_reset;
        rstn = 1'b0;
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        for (i = 0; i < 19; i = i + 1) begin
            chk(all4[i*4 +: 4], rst_vals[i*4 +: 4]);
        end
        chk({p4c, p5c, cdm, slp, ccr, rc1, ext}, 24'hffff77);
    endtask
    initial begin
        #20000;
        errors = errors + 1;
        stop_test;
    end
    initial begin
        {mclk, rstn, irq, wlock, errors, n_compared} = 0;
        wlock = 1'b1;
        {p2p, p4p, p5p, vms, wclr, sst, srx} = 32'h6932415c;
        rows = '{24'h025005, 24'h049019, 24'h059029, 24'h03e03e, 24'h0d3043,
                 24'h0fa05a, 24'h12c07c, 24'h191091, 24'h1a20a2, 24'h2050b5,
                 24'h2130c3, 24'h2240d4, 24'h2360e6, 24'h2470f7, 24'h281101,
                 24'h292112, 24'h2a3123, 24'h010005, 24'h060019, 24'h0b0029,
                 24'h0c0043, 24'h0e005a, 24'h2600b5, 24'h2b00c3, 24'h02107c,
                 24'h0a6066};
        do_reset;
        for (i = 0; i < 26; i = i + 1) begin
            if (rows[i][23:20] == 4'h1) core.out_nib(4'h8, rows[i][19:16]);
            if (rows[i][23:20] == 4'h2) core.out_nib(4'h7, rows[i][19:16]);
            if (rows[i][23:20] == 4'h2) core.out_nib(4'h7, rows[i][15:12]);
            else core.out_nib(rows[i][19:16], rows[i][15:12]);
            chk(all4[rows[i][11:4]*4 +: 4], rows[i][3:0]);
        end
        for (i = 0; i < 10; i = i + 1) begin
            core.in_nib(rd_tab[i*8+4 +: 4], got, ok);
            chk({ok, got}, {1'b1, rd_tab[i*8 +: 4]});
        end
        core.out_nib(4'h8, 4'h4);
        core.out_byte(4'h4, 8'ha5);
        core.out_nib(4'h8, 4'h5);
        core.out_byte(4'h5, 8'h3c);
        core.out_nib(4'h7, 4'h5);
        core.out_byte(4'h7, 8'h96);
        core.out_byte(4'h9, 8'h7e);
        chk({txl, stx}, {1'b1, 8'h7e});
        chk({p4c, p5c, t2o2}, 24'ha53c96);
        for (i = 0; i < 4; i = i + 1) begin
            core.out_nib(4'h8, 4'h3);
            core.out_nib(4'h3, {2'b11, i[1:0]});
            chk({dsy, cmg}, {1'b1, 2'b11, i[1:0]});
            @(negedge mclk);
            chk(cdm, css_div[i*4 +: 4]);
        end
        for (i = 3; i >= 0; i = i - 1) begin
            core.out_nib(4'h3, {2'b11, i[1:0]});
            repeat (2) @(negedge mclk);
            chk({cmg, ext, x4m, rc2, x32, d16, rc1},
                {4'hf, osc_tab[i*5 +: 5], 1'b1});
        end
        core.out_nib(4'h8, 4'h3);
        core.out_nib(4'h3, 4'hb);
        repeat (2) @(negedge mclk);
        chk(rc1, 1'b0);
        core.out_nib(4'h8, 4'h3);
        core.out_nib(4'h3, 4'h7);
        core.sleep_cmd;
        chk({slp, ies, ccr}, 3'b110);
        repeat (2) @(negedge mclk);
        chk({pcr, bor, rc1, x32}, 4'b0001);
        wlock = 1'b0;
        repeat (3) @(negedge mclk);
        chk({bor, pcr}, 2'b10);
        wlock = 1'b1;
        irq = 1'b1;
        repeat (5) @(negedge mclk);
        chk({slp, ccr}, 2'b01);
        core.sleep_cmd;
        chk(slp, 1'b0);
        irq = 1'b0;
        core.out_nib(4'h8, 4'h3);
        core.out_nib(4'h3, 4'hf);
        core.sleep_cmd;
        repeat (2) @(negedge mclk);
        chk({slp, pcr, bor}, 3'b111);
        do_reset;
        stop_test;
    end
endmodule // io_bus_regs_and_power_ctrl_tb_top

// >>> iob_core_model.sv
`timescale 1ns/10ps
module iob_core_model (
    input  wire       mclk_i,
    input  wire [3:0] io_rdata_i,
    input  wire       io_rvalid_i,
    output reg        io_wr_o,
    output reg        io_rd_o,
    output reg  [3:0] io_addr_o,
    output reg  [3:0] io_wdata_o,
    output reg        sleep_exec_o
);
    initial begin
        {io_wr_o, io_rd_o, sleep_exec_o} = 3'h0;
        {io_addr_o, io_wdata_o} = 8'h00;
    end
    task out_nib(input [3:0] a, input [3:0] d);
        @(negedge mclk_i);
        io_addr_o = a;
        io_wdata_o = d;
        io_wr_o = 1'b1;
        @(negedge mclk_i);
        io_wr_o = 1'b0;
        io_addr_o = ~a;
        io_wdata_o = ~d;
    endtask
    task in_nib(input [3:0] a, output [3:0] d, output v);
        @(negedge mclk_i);
        io_addr_o = a;
        io_rd_o = 1'b1;
        @(negedge mclk_i);
        d = io_rdata_i;
        v = io_rvalid_i;
        io_rd_o = 1'b0;
        io_addr_o = ~a;
    endtask
    task out_byte(input [3:0] a, input [7:0] b);
        out_nib(a, b[3:0]);
        out_nib(a, b[7:4]);
    endtask
    task sleep_cmd;
        repeat (3) @(negedge mclk_i);
        sleep_exec_o = 1'b1;
        @(negedge mclk_i);
        sleep_exec_o = 1'b0;
    endtask
endmodule // iob_core_model

// >>> iob_defines.vh
`ifndef IOB_DEFINES_VH
`define IOB_DEFINES_VH
// module addresses
`define IOB_A_PORT2      4'h2
`define IOB_A_SYSCFG     4'h3
`define IOB_A_PORT4      4'h4
`define IOB_A_PORT5      4'h5
`define IOB_A_TIMER      4'h7
`define IOB_A_AUXSW      4'h8
`define IOB_A_SERIAL     4'h9
`define IOB_A_SERSTAT    4'ha
`define IOB_A_ROMBANK    4'hd
`define IOB_A_VOLTMON    4'hf
// timer subport addresses
`define IOB_S_T2CTRL     4'h0
`define IOB_S_T2MODE1    4'h1
`define IOB_S_T2MODE2    4'h2
`define IOB_S_T2CMPMODE  4'h3
`define IOB_S_T2CMP1     4'h4
`define IOB_S_T2CMP2     4'h5
`define IOB_S_T1CTRL1    4'h8
`define IOB_S_T1CTRL2    4'h9
`define IOB_S_WDCTRL     4'ha
// reset values
`define IOB_R_ONES4      4'hf
`define IOB_R_ZERO4      4'h0
`define IOB_R_ONES8      8'hff
`define IOB_R_ZERO8      8'h00
`define IOB_R_SYSCFG     4'hf
`define IOB_R_CLKMGMT    4'hf
`define IOB_R_T1CTRL2    4'h7
`define IOB_R_SERSTAT    4'hb
`define IOB_R_AUXSW      4'hf
// field positions
`define IOB_F_BOT        3
`define IOB_F_OS1        1
`define IOB_F_OS0        0
`define IOB_F_KEEP       3
`define IOB_F_CCS        2
`define IOB_F_CORE_SPEED_SEL_HI       1
`define IOB_F_CORE_SPEED_SEL_LO       0
// oscillator select codes
`define IOB_OS_EXT       2'b11
`define IOB_OS_RC2       2'b01
`define IOB_OS_XT4M      2'b10
`define IOB_OS_XT32K     2'b00
// core speed select codes and divider minus one values
`define IOB_CSS_DIV16    2'b00
`define IOB_CSS_DIV8     2'b11
`define IOB_CSS_DIV4     2'b10
`define IOB_CSS_DIV2     2'b01
`define IOB_DIV16_M1     4'hf
`define IOB_DIV8_M1      4'h7
`define IOB_DIV4_M1      4'h3
`define IOB_DIV2_M1      4'h1
// io guard cycles before sleep
`define IOB_IO_GUARD     2'd3
`endif

// >>> iob_regs.v
// Behaviour
// RULE_01 - system config write-only at primary address 3
// RULE_02 - oscillator select picks sources and peripheral clock
// RULE_03 - clock source bit low stops rc oscillator one
// RULE_04 - sleep sets interrupt enable, halts core clock
// RULE_05 - interrupts or reset end sleep
// RULE_06 - pending or active interrupt prevents sleep
// RULE_07 - program leaves three idle cycles before sleep
// RULE_08 - keep bit decides peripheral clock during sleep
// RULE_09 - both clocks stopped switches oscillator off; the code keeps xt32k_run_o on when 32k is selected
// RULE_10 - oscillator stop needs sleep, stop, watchdog lock
// RULE_11 - four-bit module address decoded for sixteen modules
// RULE_12 - plain access reaches primary register
// RULE_13 - aux switch at 8 routes next access auxiliary
// RULE_14 - byte registers move as two nibbles
// RULE_15 - first out loads subport address
// RULE_16 - timer subport map at module 7
// RULE_17 - serial buffers at module 9
// RULE_18 - voltage monitor control write, status read
// RULE_19 - port data write stores, read returns pins
// RULE_20 - clock management is auxiliary of module 3
// RULE_21 - clock management write starts divider sync
// RULE_22 - core speed field selects divider 16/8/4/2
// RULE_23 - program writes low nibble before high nibble
// RULE_24 - reserved addresses have no effect
// RULE_25 - aux selection lasts one access
`timescale 1ns/10ps
`include "iob_defines.vh"
module iob_regs (
    input  wire       mclk_i,
    input  wire       rstn_i,
    input  wire       io_wr_i,
    input  wire       io_rd_i,
    input  wire [3:0] io_addr_i,
    input  wire [3:0] io_wdata_i,
    input  wire       sleep_exec_i,
    input  wire       irq_any_i,
    input  wire       wdt_lock_i,
    input  wire [3:0] port2_pins_i,
    input  wire [3:0] port4_pins_i,
    input  wire [3:0] port5_pins_i,
    input  wire [7:0] ser_rx_i,
    input  wire [3:0] vm_status_i,
    input  wire [3:0] wdt_clear_i,
    input  wire [3:0] ser_status_i,
    output reg  [3:0] io_rdata_o,
    output reg        io_rvalid_o,
    output reg  [3:0] port2_data_o,
    output reg  [3:0] port2_dir_o,
    output reg  [3:0] port4_data_o,
    output reg  [7:0] port4_ctrl_o,
    output reg  [3:0] port5_data_o,
    output reg  [7:0] port5_ctrl_o,
    output reg  [3:0] sys_config_o,
    output reg  [3:0] clock_mgmt_o,
    output reg  [7:0] ser_tx_o,
    output reg        ser_tx_load_o,
    output reg  [3:0] ser_ctrl1_o,
    output reg  [3:0] ser_statctl_o,
    output reg  [3:0] ser_ctrl2_o,
    output reg  [3:0] rom_bank_o,
    output reg  [3:0] volt_mon_ctrl_o,
    output reg  [3:0] t2_ctrl_o,
    output reg  [3:0] t2_mode1_o,
    output reg  [3:0] t2_mode2_o,
    output reg  [3:0] t2_cmpmode_o,
    output reg  [3:0] t2_cmp1_o,
    output reg  [7:0] t2_cmp2_o,
    output reg  [3:0] t1_ctrl1_o,
    output reg  [3:0] t1_ctrl2_o,
    output reg  [3:0] wdt_ctrl_o,
    output reg        irq_enable_set_o,
    output reg        sleep_o,
    output reg        core_clk_run_o,
    output reg        periph_clk_run_o,
    output reg        rc1_run_o,
    output reg        rc2_run_o,
    output reg        xt4m_run_o,
    output reg        xt32k_run_o,
    output reg        ext_clk_run_o,
    output reg        brownout_run_o,
    output reg        periph_div16_o,
    output reg  [3:0] core_div_m1_o,
    output reg        div_sync_o
);
    localparam S_RUN   = 2'b01;
    localparam S_SLEEP = 2'b10;

    // bus decode and core divider helpers
    function is_byte_aux;
        input [3:0] a;
        begin
            is_byte_aux = (a == `IOB_A_PORT4) || (a == `IOB_A_PORT5);
        end
    endfunction

    function [3:0] div_of;
        input [1:0] css;
        begin
            if (css == `IOB_CSS_DIV16)
                div_of = `IOB_DIV16_M1;
            else if (css == `IOB_CSS_DIV8)
                div_of = `IOB_DIV8_M1;
            else if (css == `IOB_CSS_DIV4)
                div_of = `IOB_DIV4_M1;
            else
                div_of = `IOB_DIV2_M1;
        end
    endfunction

    reg [3:0] aux_sel_ff;
    reg       aux_pend_ff;
    reg       nib_hi_ff;
    reg [3:0] nib_lo_ff;
    reg [3:0] sub_addr_ff;
    reg       sub_have_ff;
    reg [3:0] p2_s1_ff;
    reg [3:0] p2_s2_ff;
    reg [3:0] p4_s1_ff;
    reg [3:0] p4_s2_ff;
    reg [3:0] p5_s1_ff;
    reg [3:0] p5_s2_ff;
    reg       irq_s1_ff;
    reg       irq_s2_ff;
    reg       wdl_s1_ff;
    reg       wdl_s2_ff;
    reg       rx_hi_ff;
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    wire      aux_hit = aux_pend_ff && (aux_sel_ff == io_addr_i);
    wire      io_any  = io_wr_i || io_rd_i;

    // pin, interrupt and watchdog lock inputs synchronised
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            p2_s1_ff  <= `IOB_R_ZERO4;
            p2_s2_ff  <= `IOB_R_ZERO4;
            p4_s1_ff  <= `IOB_R_ZERO4;
            p4_s2_ff  <= `IOB_R_ZERO4;
            p5_s1_ff  <= `IOB_R_ZERO4;
            p5_s2_ff  <= `IOB_R_ZERO4;
            irq_s1_ff <= 1'b0;
            irq_s2_ff <= 1'b0;
            wdl_s1_ff <= 1'b0;
            wdl_s2_ff <= 1'b0;
        end else begin
            p2_s1_ff  <= port2_pins_i;
            p2_s2_ff  <= p2_s1_ff;
            p4_s1_ff  <= port4_pins_i;
            p4_s2_ff  <= p4_s1_ff;
            p5_s1_ff  <= port5_pins_i;
            p5_s2_ff  <= p5_s1_ff;
            irq_s1_ff <= irq_any_i;
            irq_s2_ff <= irq_s1_ff;
            wdl_s1_ff <= wdt_lock_i;
            wdl_s2_ff <= wdl_s1_ff;
        end
    end

    // register writes
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            aux_sel_ff      <= `IOB_R_AUXSW;
            aux_pend_ff     <= 1'b0;
            nib_hi_ff       <= 1'b0;
            nib_lo_ff       <= `IOB_R_ZERO4;
            sub_addr_ff     <= `IOB_R_ZERO4;
            sub_have_ff     <= 1'b0;
            port2_data_o    <= `IOB_R_ONES4;
            port2_dir_o     <= `IOB_R_ONES4;
            port4_data_o    <= `IOB_R_ONES4;
            port4_ctrl_o    <= `IOB_R_ONES8;
            port5_data_o    <= `IOB_R_ONES4;
            port5_ctrl_o    <= `IOB_R_ONES8;
            sys_config_o    <= `IOB_R_SYSCFG;
            clock_mgmt_o    <= `IOB_R_CLKMGMT;
            ser_tx_o        <= `IOB_R_ZERO8;
            ser_tx_load_o   <= 1'b0;
            ser_ctrl1_o     <= `IOB_R_ONES4;
            ser_statctl_o   <= `IOB_R_SERSTAT;
            ser_ctrl2_o     <= `IOB_R_ONES4;
            rom_bank_o      <= `IOB_R_ZERO4;
            volt_mon_ctrl_o <= `IOB_R_ONES4;
            t2_ctrl_o       <= `IOB_R_ZERO4;
            t2_mode1_o      <= `IOB_R_ONES4;
            t2_mode2_o      <= `IOB_R_ONES4;
            t2_cmpmode_o    <= `IOB_R_ZERO4;
            t2_cmp1_o       <= `IOB_R_ONES4;
            t2_cmp2_o       <= `IOB_R_ONES8;
            t1_ctrl1_o      <= `IOB_R_ONES4;
            t1_ctrl2_o      <= `IOB_R_T1CTRL2;
            wdt_ctrl_o      <= `IOB_R_ONES4;
            div_sync_o      <= 1'b0;
        end else begin
            ser_tx_load_o <= 1'b0;
            div_sync_o    <= 1'b0;
            if (io_any && aux_hit && !(io_wr_i && is_byte_aux(io_addr_i)
                    && !nib_hi_ff))
                aux_pend_ff <= 1'b0; // RULE_25
            if (io_rd_i && (io_addr_i == `IOB_A_TIMER))
                sub_have_ff <= 1'b0; // RULE_15
            if (io_wr_i) begin
                if (io_addr_i == `IOB_A_AUXSW) begin // RULE_11
                    aux_sel_ff  <= io_wdata_i; // RULE_13
                    aux_pend_ff <= 1'b1;
                end else if (io_addr_i == `IOB_A_PORT2) begin
                    if (aux_hit)
                        port2_dir_o <= io_wdata_i;
                    else
                        port2_data_o <= io_wdata_i; // RULE_19
                end else if (io_addr_i == `IOB_A_SYSCFG) begin
                    if (aux_hit) begin
                        clock_mgmt_o <= io_wdata_i; // RULE_20
                        div_sync_o   <= 1'b1; // RULE_21
                    end else
                        sys_config_o <= io_wdata_i; // RULE_01 RULE_12
                end else if (io_addr_i == `IOB_A_PORT4) begin
                    if (aux_hit) begin
                        nib_hi_ff <= !nib_hi_ff; // RULE_14
                        if (!nib_hi_ff)
                            nib_lo_ff <= io_wdata_i; // RULE_23
                        else
                            port4_ctrl_o <= {io_wdata_i, nib_lo_ff};
                    end else
                        port4_data_o <= io_wdata_i;
                end else if (io_addr_i == `IOB_A_PORT5) begin
                    if (aux_hit) begin
                        nib_hi_ff <= !nib_hi_ff; // RULE_14
                        if (!nib_hi_ff)
                            nib_lo_ff <= io_wdata_i;
                        else
                            port5_ctrl_o <= {io_wdata_i, nib_lo_ff};
                    end else
                        port5_data_o <= io_wdata_i;
                end else if (io_addr_i == `IOB_A_TIMER) begin
                    if (!sub_have_ff) begin
                        sub_addr_ff <= io_wdata_i; // RULE_15
                        sub_have_ff <= 1'b1;
                        nib_hi_ff   <= 1'b0;
                    end else if (sub_addr_ff == `IOB_S_T2CMP2) begin
                        nib_hi_ff <= !nib_hi_ff; // RULE_14
                        if (!nib_hi_ff)
                            nib_lo_ff <= io_wdata_i;
                        else begin
                            t2_cmp2_o   <= {io_wdata_i, nib_lo_ff};
                            sub_have_ff <= 1'b0;
                        end
                    end else begin
                        sub_have_ff <= 1'b0;
                        if (sub_addr_ff == `IOB_S_T2CTRL) // RULE_16
                            t2_ctrl_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T2MODE1)
                            t2_mode1_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T2MODE2)
                            t2_mode2_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T2CMPMODE)
                            t2_cmpmode_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T2CMP1)
                            t2_cmp1_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T1CTRL1)
                            t1_ctrl1_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_T1CTRL2)
                            t1_ctrl2_o <= io_wdata_i;
                        else if (sub_addr_ff == `IOB_S_WDCTRL)
                            wdt_ctrl_o <= io_wdata_i; // RULE_24
                    end
                end else if (io_addr_i == `IOB_A_SERIAL) begin
                    if (aux_hit)
                        ser_ctrl1_o <= io_wdata_i;
                    else begin
                        nib_hi_ff <= !nib_hi_ff; // RULE_14
                        if (!nib_hi_ff)
                            nib_lo_ff <= io_wdata_i;
                        else begin
                            ser_tx_o      <= {io_wdata_i, nib_lo_ff};
                            ser_tx_load_o <= 1'b1; // RULE_17
                        end
                    end
                end else if (io_addr_i == `IOB_A_SERSTAT) begin
                    if (aux_hit)
                        ser_ctrl2_o <= io_wdata_i;
                    else
                        ser_statctl_o <= io_wdata_i;
                end else if (io_addr_i == `IOB_A_ROMBANK) begin
                    rom_bank_o <= io_wdata_i;
                end else if (io_addr_i == `IOB_A_VOLTMON) begin
                    volt_mon_ctrl_o <= io_wdata_i; // RULE_18
                end
            end
        end
    end

    // register reads, one cycle latency
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            io_rdata_o  <= `IOB_R_ZERO4;
            io_rvalid_o <= 1'b0;
            rx_hi_ff    <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            io_rdata_o  <= `IOB_R_ZERO4; // RULE_24
            if (io_rd_i) begin
                if (io_addr_i == `IOB_A_PORT2)
                    io_rdata_o <= p2_s2_ff; // RULE_19
                else if (io_addr_i == `IOB_A_PORT4)
                    io_rdata_o <= p4_s2_ff;
                else if (io_addr_i == `IOB_A_PORT5)
                    io_rdata_o <= p5_s2_ff;
                else if (io_addr_i == `IOB_A_SYSCFG)
                    io_rdata_o <= wdt_clear_i;
                else if (io_addr_i == `IOB_A_SERIAL) begin
                    io_rdata_o <= rx_hi_ff ? ser_rx_i[7:4]
                                           : ser_rx_i[3:0]; // RULE_17
                    rx_hi_ff   <= !rx_hi_ff; // RULE_14
                end
                else if (io_addr_i == `IOB_A_SERSTAT)
                    io_rdata_o <= ser_status_i;
                else if (io_addr_i == `IOB_A_VOLTMON)
                    io_rdata_o <= vm_status_i; // RULE_18
            end
        end
    end

    // sleep control and clock gating
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_RUN: begin
                if (sleep_exec_i && !irq_s2_ff)
                    nxt_state = S_SLEEP; // RULE_04 RULE_06
            end
            S_SLEEP: begin
                if (irq_s2_ff)
                    nxt_state = S_RUN; // RULE_05
            end
            default: nxt_state = S_RUN;
        endcase
    end

    wire [1:0] os_sel = {sys_config_o[`IOB_F_OS1], sys_config_o[`IOB_F_OS0]};
    wire       ccs    = clock_mgmt_o[`IOB_F_CCS];
    wire       keep   = clock_mgmt_o[`IOB_F_KEEP];
    wire       nxt_sleep = (nxt_state == S_SLEEP);
    wire       osc_stop  = nxt_sleep && !keep && wdl_s2_ff; // RULE_10
    wire       run_sel   = !osc_stop; // RULE_09

    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff         <= S_RUN;
            irq_enable_set_o <= 1'b0;
            sleep_o          <= 1'b0;
            core_clk_run_o   <= 1'b1;
            periph_clk_run_o <= 1'b1;
            rc1_run_o        <= 1'b1;
            rc2_run_o        <= 1'b0;
            xt4m_run_o       <= 1'b0;
            xt32k_run_o      <= 1'b0;
            ext_clk_run_o    <= 1'b1;
            brownout_run_o   <= 1'b1;
            periph_div16_o   <= 1'b1;
            core_div_m1_o    <= `IOB_DIV8_M1;
        end else begin
            state_ff <= nxt_state;
            irq_enable_set_o <= sleep_exec_i && (state_ff == S_RUN); // RULE_04
            sleep_o          <= nxt_sleep;
            core_clk_run_o   <= !nxt_sleep; // RULE_04
            periph_clk_run_o <= !nxt_sleep || keep; // RULE_08
            rc1_run_o        <= ccs && run_sel; // RULE_03
            rc2_run_o        <= (os_sel == `IOB_OS_RC2) && run_sel; // RULE_02
            xt4m_run_o       <= (os_sel == `IOB_OS_XT4M) && run_sel;
            xt32k_run_o      <= (os_sel == `IOB_OS_XT32K); // RULE_09
            ext_clk_run_o    <= (os_sel == `IOB_OS_EXT) && run_sel;
            brownout_run_o   <= run_sel; // RULE_10
            periph_div16_o   <= (os_sel != `IOB_OS_XT32K); // RULE_02
            if (div_sync_o)
                core_div_m1_o <= div_of({clock_mgmt_o[`IOB_F_CORE_SPEED_SEL_HI],
                                         clock_mgmt_o[`IOB_F_CORE_SPEED_SEL_LO]}); // RULE_22
        end
    end
endmodule // iob_regs

// >>> iob_regs_checker.sv
`timescale 1ns/10ps
module iob_regs_checker (
    input wire       mclk_i,
    input wire       rstn_i,
    input wire       io_rd_i,
    input wire       irq_any_i,
    input wire       sleep_exec_i,
    input wire       io_rvalid_o,
    input wire       irq_enable_set_o,
    input wire       sleep_o,
    input wire       periph_clk_run_o,
    input wire       rc1_run_o,
    input wire       xt32k_run_o,
    input wire       brownout_run_o,
    input wire       div_sync_o,
    input wire [3:0] sys_config_o,
    input wire [3:0] clock_mgmt_o,
    input wire [3:0] core_div_m1_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    function automatic [3:0] div_m1(input [3:0] c);
        div_m1 = (c[1:0] == 2'b00) ? 4'hf : (c[1:0] == 2'b11) ? 4'h7 :
                 (c[1:0] == 2'b10) ? 4'h3 : 4'h1;
    endfunction
    property p_rd_ans;
        io_rd_i |=> io_rvalid_o;
    endproperty
    property p_sleep_go;
        $rose(sleep_o) |-> $past(sleep_exec_i) && irq_enable_set_o;
    endproperty
    property p_irq_wake;
        irq_any_i [*4] |=> !sleep_o;
    endproperty
    property p_rc1_stop;
        !clock_mgmt_o[2] [*2] |-> !rc1_run_o;
    endproperty
    property p_sync;
        $changed(clock_mgmt_o) |-> div_sync_o;
    endproperty
    property p_div;
        div_sync_o |=> core_div_m1_o == div_m1($past(clock_mgmt_o));
    endproperty
    property p_keep;
        clock_mgmt_o[3] [*2] |-> periph_clk_run_o;
    endproperty
    property p_osc_run;
        !sleep_o [*2] |-> brownout_run_o;
    endproperty
    property p_xt32k;
        (sys_config_o[1:0] == 2'b00) [*2] |-> xt32k_run_o;
    endproperty
    a_rd_ans: assert property (p_rd_ans)
        else $error("read not answered");
    a_sleep_go: assert property (p_sleep_go)
        else $error("sleep entered without cause");
    a_irq_wake: assert property (p_irq_wake)
        else $error("sleep held with irq");
    a_rc1_stop: assert property (p_rc1_stop)
        else $error("rc1 runs with ccs low");
    a_sync: assert property (p_sync)
        else $error("clock mgmt change without sync");
    a_div: assert property (p_div)
        else $error("wrong core divider");
    a_keep: assert property (p_keep)
        else $error("peripheral clock stopped with keep");
    a_osc_run: assert property (p_osc_run)
        else $error("brownout stopped while awake");
    a_xt32k: assert property (p_xt32k)
        else $error("32k oscillator stopped");
    c_sleep: cover property ($rose(sleep_o));
    c_wake: cover property ($fell(sleep_o));
    c_div: cover property (div_sync_o ##1 core_div_m1_o == 4'hf);
    c_read: cover property (io_rvalid_o);
endmodule // iob_regs_checker

bind iob_regs iob_regs_checker u_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .io_rd_i(io_rd_i),
    .irq_any_i(irq_any_i), .sleep_exec_i(sleep_exec_i),
    .io_rvalid_o(io_rvalid_o), .irq_enable_set_o(irq_enable_set_o),
    .sleep_o(sleep_o), .periph_clk_run_o(periph_clk_run_o),
    .rc1_run_o(rc1_run_o), .xt32k_run_o(xt32k_run_o),
    .brownout_run_o(brownout_run_o), .div_sync_o(div_sync_o),
    .sys_config_o(sys_config_o), .clock_mgmt_o(clock_mgmt_o),
    .core_div_m1_o(core_div_m1_o)
);
